/* File: pdm_bright_mix.sv */
// Selects and weights internal and external brightness readings.
// Assumes readings are whole lux values already decoded from the bus.
`timescale 1ns/1ns
`default_nettype none
module pdm_bright_mix
  import pdm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] src,
  input wire logic [4:0] weight_idx,
  input wire logic [15:0] int_lux,
  input wire logic [15:0] ext_lux,
  output logic [15:0] eff_lux_ff
);
  logic [4:0] widx;
  logic [6:0] w_int;
  logic [6:0] w_ext;
  logic [22:0] sum;
  logic [15:0] comb;
  logic [15:0] nxt_eff_lux;

  assign widx = (weight_idx > WEIGHT_LAST) ? WEIGHT_LAST : weight_idx;
  assign w_int = WEIGHT_TOP - 7'(WEIGHT_STEP * 7'(widx));
  assign w_ext = PERCENT_FULL - w_int;
  assign sum = 23'(int_lux) * 23'(w_int) + 23'(ext_lux) * 23'(w_ext);
  assign comb = 16'(sum / 23'(PERCENT_FULL));
  assign nxt_eff_lux = (src == SRC_EXT) ? ext_lux :
                       (src == SRC_COMB) ? comb : int_lux;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eff_lux_ff <= 16'h0000;
    end else begin
      eff_lux_ff <= nxt_eff_lux;
    end
  end
endmodule // pdm_bright_mix
`default_nettype wire

/* File: pdm_bus_model.sv */
// Far side model: actuators that take the telegrams of both outputs and the feedback.
// Assumes telegrams are one-cycle pulses on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module pdm_bus_model (
  input wire logic clk,
  input wire logic v1,
  input wire logic [15:0] d1,
  input wire logic [1:0] s1,
  input wire logic v2,
  input wire logic [15:0] d2,
  input wire logic v3,
  input wire logic [15:0] d3,
  output logic [15:0] q1,
  output logic [1:0] z1,
  output int n1,
  output logic [15:0] q2,
  output int n2,
  output logic [15:0] q3,
  output int n3
);
  initial begin
    {q1, z1, q2, q3} = '0;
    {n1, n2, n3} = '0;
  end
  // Each actuator keeps the last telegram and counts them.
  always @(posedge clk) begin
    if (v1 === 1'b1) begin
      q1 <= d1;
      z1 <= s1;
      n1 <= n1 + 1;
    end
    if (v2 === 1'b1) begin
      q2 <= d2;
      n2 <= n2 + 1;
    end
    if (v3 === 1'b1) begin
      q3 <= d3;
      n3 <= n3 + 1;
    end
  end
endmodule // pdm_bus_model
`default_nettype wire

/* File: pdm_motion_block.sv */
// One motion detection block: outputs, sector combining, brightness gating.
// Assumes single-cycle strobes from the bus interface and decoded lux values.
`timescale 1ns/1ns
`default_nettype none
module pdm_motion_block
  import pdm_pkg::*;
#(
  parameter longint unsigned STAIR_CYCLES = STAIR_CYC
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [2:0] sector_motion,
  input wire logic [15:0] int_lux,
  input wire logic [15:0] ext_lux,
  input wire logic [15:0] preset_lux,
  input wire logic preset_stb,
  input wire logic teach_stb,
  input wire logic download_stb,
  input wire logic bus_return_stb,
  input wire logic block_active,
  input wire logic det_end_stb,
  output logic motion_accept,
  output logic det_active,
  output logic out1_present,
  output logic out1_valid,
  output logic [15:0] out1_data,
  output logic [1:0] out1_size,
  output logic out2_present,
  output logic out2_valid,
  output logic [15:0] out2_data,
  output logic [1:0] out2_size,
  output logic tw_fb_valid,
  output logic [15:0] tw_fb_data
);

  // Reset release through two flip-flops.
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // Configuration registers.
  logic [15:0] outcfg_ff;
  logic [15:0] brcfg_ff;
  logic [15:0] twcfg_ff;
  logic [15:0] out1val_ff;
  logic [15:0] out2val_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      outcfg_ff <= OUTCFG_RST;
      brcfg_ff <= BRCFG_RST;
      twcfg_ff <= TW_DEFAULT;
      out1val_ff <= OUTVAL_RST;
      out2val_ff <= OUTVAL_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_OUTCFG) begin
        outcfg_ff <= reg_wdata;
      end
      if (reg_addr == ADDR_BRCFG) begin
        brcfg_ff <= reg_wdata;
      end
      if (reg_addr == ADDR_TWCFG) begin
        twcfg_ff <= reg_wdata;
      end
      if (reg_addr == ADDR_OUT1VAL) begin
        out1val_ff <= reg_wdata;
      end
      if (reg_addr == ADDR_OUT2VAL) begin
        out2val_ff <= reg_wdata;
      end
    end
  end

  // Field decode.
  wire [3:0] cfg_mode1 = outcfg_ff[OUT1_MODE_LSB +: 4];
  wire [3:0] cfg_mode2 = outcfg_ff[OUT2_MODE_LSB +: 4];
  wire [1:0] app = outcfg_ff[APP_LSB +: 2];
  wire [2:0] sector_mask = outcfg_ff[SECTOR_LSB +: 3];
  wire restart_detect = outcfg_ff[RESTART_BIT];
  wire [1:0] br_src = brcfg_ff[SRC_LSB +: 2];
  wire [4:0] weight_idx = brcfg_ff[WEIGHT_LSB +: 5];
  wire br_dep = brcfg_ff[DEP_BIT];
  wire tw_overwrite = brcfg_ff[OVERWRITE_BIT];
  wire preset_en = brcfg_ff[PRESET_EN_BIT];
  wire fb_active = brcfg_ff[FB_ACTIVE_BIT];

  // Effective output modes after the application type is applied.
  wire is_ext = (app == APP_EXT);
  wire is_det = (app == APP_DETECTOR);
  wire [3:0] mode1 = is_ext ? OM_NONE :
                     is_det ? OM_SWITCH : cfg_mode1;
  wire [3:0] mode2 = (is_ext || is_det) ? OM_NONE : cfg_mode2;

  assign out1_present = (mode1 != OM_NONE) && (mode1 <= OM_HVAC);
  assign out2_present = (mode2 != OM_NONE) && (mode2 <= OM_HVAC);

  // Configured twilight level kept inside its legal span.
  wire [15:0] tw_cfg_clamped = (twcfg_ff < TW_MIN) ? TW_MIN :
                               (twcfg_ff > TW_MAX) ? TW_MAX : twcfg_ff;

  // Brightness selection and weighting.
  logic [15:0] eff_lux;

  pdm_bright_mix u_mix (
    .clk(clk),
    .rst_n(rst_n_ff),
    .src(br_src),
    .weight_idx(weight_idx),
    .int_lux(int_lux),
    .ext_lux(ext_lux),
    .eff_lux_ff(eff_lux)
  );

  // Twilight level; an externally set value is held until a new preset or teach, or a download with overwrite set.
  logic [15:0] tw_ff;
  logic ext_set_ff;
  logic [15:0] nxt_tw;
  logic nxt_ext_set;

  wire preset_hit = preset_en && preset_stb;
  wire teach_hit = teach_stb;
  wire dl_restore = download_stb && (tw_overwrite || !ext_set_ff);

  always_comb begin
    nxt_tw = tw_ff;
    nxt_ext_set = ext_set_ff;
    if (preset_hit) begin
      nxt_tw = preset_lux;
      nxt_ext_set = 1'b1;
    end else if (teach_hit) begin
      nxt_tw = eff_lux;
      nxt_ext_set = 1'b1;
    end else if (dl_restore) begin
      nxt_tw = tw_cfg_clamped;
      nxt_ext_set = 1'b0;
    end else if (!ext_set_ff) begin
      nxt_tw = tw_cfg_clamped;
    end
  end

  // Bus voltage return leaves these alone; reset loads TW_DEFAULT, and a download with overwrite set also clears ext_set_ff.
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tw_ff <= TW_DEFAULT;
      ext_set_ff <= 1'b0;
    end else begin
      tw_ff <= nxt_tw;
      ext_set_ff <= nxt_ext_set;
    end
  end

  // Active twilight feedback.
  logic [15:0] tw_last_ff;
  logic fb_valid_ff;
  logic [15:0] fb_data_ff;

  wire fb_send = fb_active && ((tw_ff != tw_last_ff) || download_stb
                 || bus_return_stb);

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tw_last_ff <= TW_DEFAULT;
      fb_valid_ff <= 1'b0;
      fb_data_ff <= 16'h0000;
    end else begin
      tw_last_ff <= tw_ff;
      fb_valid_ff <= fb_send;
      if (fb_send) begin
        fb_data_ff <= tw_ff;
      end
    end
  end

  assign tw_fb_valid = fb_valid_ff;
  assign tw_fb_data = fb_data_ff;

  // Motion combining and gating.
  pdm_state_type state_ff;
  pdm_state_type nxt_state;

  wire motion_any = |(sector_motion & sector_mask);
  wire dark_enough = (eff_lux < tw_ff);
  wire bright_ok = !br_dep || dark_enough;
  wire start_motion = block_active && (state_ff == ST_IDLE) && motion_any && bright_ok;
  wire restart_evt = (download_stb || bus_return_stb) && block_active
                     && restart_detect;
  wire start_det = start_motion || (restart_evt && bright_ok);
  wire end_det = (state_ff == ST_DETECT) && det_end_stb;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_det) begin
          nxt_state = ST_DETECT;
        end
      end
      ST_DETECT: begin
        if (end_det) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign motion_accept = start_motion;
  assign det_active = (state_ff == ST_DETECT);

  // Staircase repetition timer, running only during a detection.
  logic [39:0] stair_cnt_ff;
  logic [39:0] nxt_stair_cnt;

  wire stair_any = (mode1 == OM_STAIR) || (mode2 == OM_STAIR);
  wire stair_tick = det_active && stair_any
                    && (stair_cnt_ff == 40'(STAIR_CYCLES - 1));

  assign nxt_stair_cnt = (!det_active || start_det || stair_tick) ? 40'h0000000000
                         : stair_cnt_ff + 40'h0000000001;

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      stair_cnt_ff <= 40'h0000000000;
    end else begin
      stair_cnt_ff <= nxt_stair_cnt;
    end
  end

  // Telegram triggers for both outputs.
  wire edge_send = (start_det && (state_ff == ST_IDLE)) || end_det;
  wire send_on = start_det && (state_ff == ST_IDLE);
  wire send1 = edge_send || (stair_tick && (mode1 == OM_STAIR));
  wire send2 = edge_send || (stair_tick && (mode2 == OM_STAIR));
  wire on1 = send_on || (stair_tick && !end_det);

  pdm_out_enc u_out1 (
    .clk(clk),
    .rst_n(rst_n_ff),
    .mode(mode1),
    .send(send1),
    .on(on1),
    .on_val(out1val_ff[7:0]),
    .off_val(out1val_ff[15:8]),
    .valid_ff(out1_valid),
    .data_ff(out1_data),
    .size_ff(out1_size)
  );

  pdm_out_enc u_out2 (
    .clk(clk),
    .rst_n(rst_n_ff),
    .mode(mode2),
    .send(send2),
    .on(on1),
    .on_val(out2val_ff[7:0]),
    .off_val(out2val_ff[15:8]),
    .valid_ff(out2_valid),
    .data_ff(out2_data),
    .size_ff(out2_size)
  );

  // Register read path, data one cycle after the strobe.
  wire [15:0] status_word = {12'h000, ext_set_ff, motion_any, dark_enough, det_active};

  always_comb begin
    case (reg_addr)
      ADDR_OUTCFG: nxt_rdata = outcfg_ff;
      ADDR_BRCFG: nxt_rdata = brcfg_ff;
      ADDR_TWCFG: nxt_rdata = twcfg_ff;
      ADDR_OUT1VAL: nxt_rdata = out1val_ff;
      ADDR_OUT2VAL: nxt_rdata = out2val_ff;
      ADDR_STATUS: nxt_rdata = status_word;
      ADDR_EFFLUX: nxt_rdata = eff_lux;
      ADDR_ACTTW: nxt_rdata = tw_ff;
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule // pdm_motion_block
`default_nettype wire

/* File: pdm_motion_block_checker.sv */
// Concurrent checks on the ports of the motion block.
// Assumes it is bound to pdm_motion_block and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module pdm_motion_block_checker
  import pdm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0] sector_motion,
  input wire logic block_active,
  input wire logic det_end_stb,
  input wire logic download_stb,
  input wire logic bus_return_stb,
  input wire logic motion_accept,
  input wire logic det_active,
  input wire logic out1_present,
  input wire logic out1_valid,
  input wire logic [15:0] out1_data,
  input wire logic [1:0] out1_size,
  input wire logic out2_present,
  input wire logic out2_valid,
  input wire logic tw_fb_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_accept_cause;
    motion_accept |-> sector_motion != 3'h0;
  endproperty
  a_accept_cause: assert property (p_accept_cause) else $error("accept without motion");
  property p_accept_active;
    motion_accept |-> block_active;
  endproperty
  a_accept_active: assert property (p_accept_active) else $error("accept while inactive");
  property p_accept_idle;
    motion_accept |-> !det_active;
  endproperty
  a_accept_idle: assert property (p_accept_idle) else $error("accept while detecting");
  property p_accept_start;
    motion_accept |=> det_active;
  endproperty
  a_accept_start: assert property (p_accept_start) else $error("no detection started");
  property p_on_sent;
    motion_accept && out1_present |=> out1_valid;
  endproperty
  a_on_sent: assert property (p_on_sent) else $error("no start telegram");
  property p_absent_quiet;
    !out2_present && !$past(out2_present) |-> !out2_valid;
  endproperty
  a_absent_quiet: assert property (p_absent_quiet) else $error("absent output sent");
  property p_bit_size;
    out1_valid && out1_size == SIZE_1BIT |-> out1_data[15:1] == 15'h0000;
  endproperty
  a_bit_size: assert property (p_bit_size) else $error("one-bit data too wide");
  property p_end_stop;
    det_active && det_end_stb |=> !det_active ##1 (!det_active || $past(motion_accept)
      || $past(download_stb) || $past(bus_return_stb));
  endproperty
  a_end_stop: assert property (p_end_stop) else $error("detection did not end");
  property p_end_off;
    det_active && det_end_stb && out1_present |=> out1_valid;
  endproperty
  a_end_off: assert property (p_end_off) else $error("no end telegram");
  property p_hold;
    det_active && !det_end_stb && !download_stb && !bus_return_stb |=> det_active;
  endproperty
  a_hold: assert property (p_hold) else $error("detection dropped");
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  c_accept: cover property (motion_accept);
  c_end: cover property (det_active && det_end_stb);
  c_fb: cover property (tw_fb_valid);
endmodule // pdm_motion_block_checker
bind pdm_motion_block pdm_motion_block_checker chk_u (.clk(clk), .arst_n(arst_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sector_motion(sector_motion),
  .block_active(block_active), .det_end_stb(det_end_stb), .download_stb(download_stb),
  .bus_return_stb(bus_return_stb), .motion_accept(motion_accept), .det_active(det_active),
  .out1_present(out1_present), .out1_valid(out1_valid), .out1_data(out1_data),
  .out1_size(out1_size), .out2_present(out2_present), .out2_valid(out2_valid),
  .tw_fb_valid(tw_fb_valid));
`default_nettype wire

/* File: pdm_out_enc.sv */
// Encodes one output telegram from its mode and its on and off parameters.
// Assumes send is a one-cycle pulse and on is the level to be sent.
`timescale 1ns/1ns
`default_nettype none
module pdm_out_enc
  import pdm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] mode,
  input wire logic send,
  input wire logic on,
  input wire logic [7:0] on_val,
  input wire logic [7:0] off_val,
  output logic valid_ff,
  output logic [15:0] data_ff,
  output logic [1:0] size_ff
);
  // Packs a value in hundredths into the two-byte float format.
  function automatic logic [15:0] to_f16(input logic [19:0] v);
    logic [19:0] m;
    logic [3:0] e;
    m = v;
    e = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (m > 20'h007FF) begin
        m = m >> 1;
        e = e + 4'h1;
      end
    end
    return {1'b0, e, m[10:0]};
  endfunction

  logic [7:0] p;
  logic [7:0] dim_p;
  logic [7:0] scn;
  logic [7:0] tmp;
  logic [7:0] lx;
  logic [15:0] nxt_data;
  logic [1:0] nxt_size;

  assign p = on ? on_val : off_val;
  assign dim_p = (p > DIM_MAX_PCT) ? DIM_MAX_PCT : p;
  assign scn = (p == 8'h00) ? 8'h01 : ((p > SCENE_MAX) ? SCENE_MAX : p);
  assign tmp = (p > TEMP_MAX_C) ? TEMP_MAX_C : p;
  assign lx = (p > LUX_STEPS_MAX) ? LUX_STEPS_MAX : p;

  always_comb begin
    nxt_data = 16'h0000;
    nxt_size = SIZE_1BIT;
    case (mode)
      OM_SWITCH, OM_STAIR: begin
        nxt_data = {15'h0000, on};
      end
      OM_FORCED: begin
        nxt_data = {14'h0000, 1'b1, on};
        nxt_size = SIZE_2BIT;
      end
      OM_DIM: begin
        nxt_data = {8'h00, 8'(16'(dim_p) * 16'h00FF / 16'(DIM_MAX_PCT))};
        nxt_size = SIZE_1BYTE;
      end
      OM_SCENE: begin
        nxt_data = {8'h00, scn - 8'h01};
        nxt_size = SIZE_1BYTE;
      end
      OM_TEMP: begin
        nxt_data = to_f16(20'(tmp) * 20'h00064);
        nxt_size = SIZE_2BYTE;
      end
      OM_LUX: begin
        nxt_data = to_f16(20'(lx) * 20'(LUX_STEP) * 20'h00064);
        nxt_size = SIZE_2BYTE;
      end
      OM_HVAC: begin
        nxt_data = {8'h00, (p > HVAC_MAX) ? 8'h00 : p};
        nxt_size = SIZE_1BYTE;
      end
      default: begin
        nxt_data = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= 1'b0;
      data_ff <= 16'h0000;
      size_ff <= SIZE_1BIT;
    end else begin
      valid_ff <= send && (mode != OM_NONE) && (mode <= OM_HVAC);
      if (send) begin
        data_ff <= nxt_data;
        size_ff <= nxt_size;
      end
    end
  end
endmodule // pdm_out_enc
`default_nettype wire

/* File: pdm_pkg.sv */
// Constants and types for the motion block output and brightness evaluation.
// Assumes a 10 MHz clock and a plain register port with 16-bit data.
package pdm_pkg;

  localparam int unsigned CLK_HZ = 10000000;
  // Period of the cyclic staircase repetition, in seconds.
  localparam int unsigned STAIR_PERIOD_S = 60;
  localparam longint unsigned STAIR_CYC = longint'(STAIR_PERIOD_S) * longint'(CLK_HZ);

  // Register indices.
  localparam logic [3:0] ADDR_OUTCFG = 4'h0;
  localparam logic [3:0] ADDR_BRCFG = 4'h1;
  localparam logic [3:0] ADDR_TWCFG = 4'h2;
  localparam logic [3:0] ADDR_OUT1VAL = 4'h3;
  localparam logic [3:0] ADDR_OUT2VAL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_EFFLUX = 4'h6;
  localparam logic [3:0] ADDR_ACTTW = 4'h7;

  // Field positions of the output configuration register.
  localparam int OUT1_MODE_LSB = 0;
  localparam int OUT2_MODE_LSB = 4;
  localparam int APP_LSB = 8;
  localparam int SECTOR_LSB = 10;
  localparam int RESTART_BIT = 13;

  // Field positions of the brightness configuration register.
  localparam int SRC_LSB = 0;
  localparam int WEIGHT_LSB = 2;
  localparam int DEP_BIT = 7;
  localparam int OVERWRITE_BIT = 8;
  localparam int PRESET_EN_BIT = 9;
  localparam int FB_ACTIVE_BIT = 10;

  // Reset values and twilight level limits.
  localparam logic [15:0] OUTCFG_RST = 16'h0011;
  localparam logic [15:0] BRCFG_RST = 16'h0000;
  localparam logic [15:0] OUTVAL_RST = 16'h0000;
  localparam logic [15:0] TW_DEFAULT = 16'h01F4;
  localparam logic [15:0] TW_MIN = 16'h000A;
  localparam logic [15:0] TW_MAX = 16'h07D0;

  // Brightness weighting: internal share is 95 % minus 5 % per step.
  localparam logic [6:0] WEIGHT_TOP = 7'h5F;
  localparam logic [6:0] WEIGHT_STEP = 7'h05;
  localparam logic [4:0] WEIGHT_LAST = 5'h12;
  localparam logic [6:0] PERCENT_FULL = 7'h64;

  // Setpoint limits and scales.
  localparam logic [7:0] DIM_MAX_PCT = 8'h64;
  localparam logic [7:0] SCENE_MAX = 8'h40;
  localparam logic [7:0] TEMP_MAX_C = 8'h28;
  localparam logic [7:0] LUX_STEPS_MAX = 8'h28;
  localparam logic [7:0] LUX_STEP = 8'h32;
  localparam logic [7:0] HVAC_MAX = 8'h04;

  // Telegram sizes.
  localparam logic [1:0] SIZE_1BIT = 2'h0;
  localparam logic [1:0] SIZE_2BIT = 2'h1;
  localparam logic [1:0] SIZE_1BYTE = 2'h2;
  localparam logic [1:0] SIZE_2BYTE = 2'h3;

  typedef enum logic [3:0] {
    OM_NONE = 4'h0,
    OM_SWITCH = 4'h1,
    OM_STAIR = 4'h2,
    OM_FORCED = 4'h3,
    OM_DIM = 4'h4,
    OM_SCENE = 4'h5,
    OM_TEMP = 4'h6,
    OM_LUX = 4'h7,
    OM_HVAC = 4'h8
  } pdm_omode_type;

  typedef enum logic [1:0] {
    APP_SINGLE = 2'h0,
    APP_MAIN = 2'h1,
    APP_EXT = 2'h2,
    APP_DETECTOR = 2'h3
  } pdm_app_type;

  typedef enum logic [1:0] {
    SRC_INT = 2'h0,
    SRC_EXT = 2'h1,
    SRC_COMB = 2'h2
  } pdm_src_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DETECT = 1'b1
  } pdm_state_type;

endpackage

/* File: tb_pdm_motion_block.sv */
// Self-checking bench for the motion block.
// Assumes the far side model in pdm_bus_model and a 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_pdm_motion_block
  import pdm_pkg::*;
;
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, preset_stb = 0, teach_stb = 0;
  logic download_stb = 0, bus_return_stb = 0, block_active = 1, det_end_stb = 0;
  logic [3:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, int_lux = 0, ext_lux = 0, preset_lux = 0, reg_rdata;
  logic [2:0] sector_motion = 0;
  logic motion_accept, det_active, out1_present, out1_valid, out2_present, out2_valid;
  logic tw_fb_valid;
  logic [15:0] out1_data, out2_data, tw_fb_data, q1, q2, q3;
  logic [1:0] out1_size, out2_size, z1;
  int n1, n2, n3, n_mismatch = 0, checks = 0;
  localparam logic [15:0] E_ON [6] = '{16'h0003, 16'h0033, 16'h0004, 16'h07D0, 16'h1CE2, 16'h0001};
  localparam logic [7:0] P_ON [6] = '{8'h01, 8'h14, 8'h05, 8'h14, 8'h02, 8'h01};
  localparam logic [1:0] E_SZ [6] = '{SIZE_2BIT, SIZE_1BYTE, SIZE_1BYTE, SIZE_2BYTE, SIZE_2BYTE,
    SIZE_1BYTE};
  pdm_motion_block #(.STAIR_CYCLES(20)) dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sector_motion(sector_motion), .int_lux(int_lux), .ext_lux(ext_lux),
    .preset_lux(preset_lux), .preset_stb(preset_stb), .teach_stb(teach_stb),
    .download_stb(download_stb), .bus_return_stb(bus_return_stb), .block_active(block_active),
    .det_end_stb(det_end_stb), .motion_accept(motion_accept), .det_active(det_active),
    .out1_present(out1_present), .out1_valid(out1_valid), .out1_data(out1_data),
    .out1_size(out1_size), .out2_present(out2_present), .out2_valid(out2_valid),
    .out2_data(out2_data), .out2_size(out2_size), .tw_fb_valid(tw_fb_valid),
    .tw_fb_data(tw_fb_data));
  pdm_bus_model bus_u (.clk(clk), .v1(out1_valid), .d1(out1_data), .s1(out1_size),
    .v2(out2_valid), .d2(out2_data), .v3(tw_fb_valid), .d3(tw_fb_data), .q1(q1), .z1(z1),
    .n1(n1), .q2(q2), .n2(n2), .q3(q3), .n3(n3));
  always #50 clk = ~clk;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask
  // Event pulses: 0 preset, 1 teach, 2 download, 3 bus return, 4 detection end.
  task automatic ev(input int k);
    @(posedge clk);
    case (k)
      0: preset_stb <= 1'b1;
      1: teach_stb <= 1'b1;
      2: download_stb <= 1'b1;
      3: bus_return_stb <= 1'b1;
      default: det_end_stb <= 1'b1;
    endcase
    @(posedge clk);
    {preset_stb, teach_stb, download_stb, bus_return_stb, det_end_stb} <= 5'h00;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic mot(input logic [2:0] s);
    @(posedge clk);
    sector_motion <= s;
    @(posedge clk);
    sector_motion <= 3'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    rd("outcfg", ADDR_OUTCFG, OUTCFG_RST);
    wr(4'hA, 16'h1234);
    rd("unmapped", 4'hA, 16'h0000);
    rd("twcfg", ADDR_TWCFG, TW_DEFAULT);
    rd("acttw", ADDR_ACTTW, TW_DEFAULT);
  endtask
  task automatic t_switch();
    int c;
    wr(ADDR_OUTCFG, 16'h0811);
    mot(3'b001);
    chk("unassigned", det_active, 1'b0);
    mot(3'b110);
    chk("on1", q1, 16'h0001);
    chk("size1", z1, SIZE_1BIT);
    chk("on2", q2, 16'h0001);
    c = n1;
    mot(3'b010);
    chk("retrig", n1 - c, 0);
    ev(4);
    chk("off1", q1, 16'h0000);
    wr(ADDR_OUTCFG, 16'h0801);
    c = n2;
    mot(3'b010);
    chk("present2", out2_present, 1'b0);
    ev(4);
    chk("silent2", n2 - c, 0);
  endtask
  task automatic t_modes();
    int c;
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_OUTCFG, 16'h0503 + 16'(i));
      wr(ADDR_OUT1VAL, {8'h00, P_ON[i]});
      mot(3'b001);
      chk("mode on", q1, E_ON[i]);
      chk("mode size", z1, E_SZ[i]);
      ev(4);
      chk("mode off", q1, (i == 0) ? 16'h0002 : 16'h0000);
    end
    wr(ADDR_OUTCFG, 16'h0532);
    mot(3'b001);
    chk("size2", out2_size, SIZE_2BIT);
    chk("forced2", q2, 16'h0003);
    c = n1;
    repeat (42) @(posedge clk);
    #1 chk("stair repeats", n1 - c, 2);
    ev(4);
  endtask
  task automatic t_apps();
    int c;
    wr(ADDR_OUTCFG, 16'h0644);
    c = n1;
    mot(3'b001);
    chk("ext present", {out1_present, out2_present}, 2'b00);
    ev(4);
    chk("ext silent", n1 - c, 0);
    wr(ADDR_OUTCFG, 16'h0714);
    mot(3'b001);
    chk("det present2", out2_present, 1'b0);
    chk("det size", z1, SIZE_1BIT);
    chk("det on", q1, 16'h0001);
    ev(4);
  endtask
  task automatic t_inactive();
    wr(ADDR_OUTCFG, 16'h2501);
    block_active <= 1'b0;
    mot(3'b001);
    ev(2);
    chk("inactive", det_active, 1'b0);
    @(posedge clk) block_active <= 1'b1;
    ev(2);
    chk("restart", det_active, 1'b1);
    ev(4);
  endtask
  task automatic t_bright();
    wr(ADDR_OUTCFG, 16'h0501);
    int_lux <= 16'd100;
    ext_lux <= 16'd200;
    wr(ADDR_BRCFG, 16'h0000);
    rd("eff int", ADDR_EFFLUX, 16'd100);
    wr(ADDR_BRCFG, 16'h0001);
    rd("eff ext", ADDR_EFFLUX, 16'd200);
    wr(ADDR_BRCFG, 16'h0002);
    rd("eff 95", ADDR_EFFLUX, 16'd105);
    wr(ADDR_BRCFG, 16'h0012);
    rd("eff 75", ADDR_EFFLUX, 16'd125);
    wr(ADDR_BRCFG, 16'h004A);
    rd("eff 5", ADDR_EFFLUX, 16'd195);
    wr(ADDR_BRCFG, 16'h0082);
    mot(3'b001);
    chk("dark", det_active, 1'b1);
    ev(4);
    @(posedge clk) int_lux <= 16'd600;
    ext_lux <= 16'd600;
    mot(3'b001);
    chk("bright", det_active, 1'b0);
    wr(ADDR_BRCFG, 16'h0002);
    mot(3'b001);
    chk("indep", det_active, 1'b1);
    ev(4);
  endtask
  task automatic t_tw();
    int c;
    @(posedge clk) int_lux <= 16'd100;
    wr(ADDR_BRCFG, 16'h0600);
    preset_lux <= 16'd300;
    ev(0);
    rd("preset", ADDR_ACTTW, 16'd300);
    chk("fb", q3, 16'd300);
    ev(3);
    rd("bus return", ADDR_ACTTW, 16'd300);
    c = n3;
    ev(2);
    rd("keep", ADDR_ACTTW, 16'd300);
    chk("fb dl", n3 - c, 1);
    ev(1);
    rd("teach", ADDR_ACTTW, 16'd100);
    wr(ADDR_BRCFG, 16'h0400);
    preset_lux <= 16'd900;
    ev(0);
    rd("preset off", ADDR_ACTTW, 16'd100);
    wr(ADDR_BRCFG, 16'h0500);
    ev(2);
    rd("overwrite", ADDR_ACTTW, TW_DEFAULT);
    wr(ADDR_TWCFG, 16'd5);
    rd("tw low", ADDR_ACTTW, TW_MIN);
    wr(ADDR_TWCFG, 16'd3000);
    rd("tw high", ADDR_ACTTW, TW_MAX);
  endtask
  task automatic print_verdict();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_switch();
    t_modes();
    t_apps();
    t_inactive();
    t_bright();
    t_tw();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule // tb_pdm_motion_block
`default_nettype wire
